// ### rtl/port_regs_pkg.sv
// Constants, register map and field layout for the port status/PHY control.
//
// Behaviour
// - External port speed copies control bits
// - PHY port speed shows real link speed
// - External port duplex copies control bit six
// - PHY port duplex shows real link duplex
// - External port transmit pause copies bit five
// - External port receive pause copies bit three
// - PHY pause status needs advert, link, resolution
// - PHY window exists only on PHY ports
// - Basic control word sits at offset 0x100
// - Bit 15 resets PHY, then clears itself
// - Bit 14 loops egress traffic back inward
// - Bit 13 forces speed unless negotiation on
// - Bit 12 enables negotiation, strap sets default
// - Leaving power down resets; wait 1 ms
// - Bit 9 restarts negotiation, clears itself
package port_regs_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam logic [11:0] OFF_PORT_LINK_STATUS   = 12'h030;
    localparam logic [11:0] OFF_EXT_MAC_CTRL_A     = 12'h040;
    localparam logic [11:0] OFF_EXT_MAC_CTRL_B     = 12'h044;
    localparam logic [11:0] OFF_PAUSE_ADVERT       = 12'h048;
    localparam logic [11:0] OFF_PHY_STATE          = 12'h04c;
    localparam logic [11:0] OFF_PHY_BASIC_CONTROL  = 12'h100;
    localparam logic [11:0] PHY_WIN_LO             = 12'h100;
    localparam logic [11:0] PHY_WIN_HI             = 12'h1ff;

    // -----------------------------------------------------------------
    // Basic control word fields
    // -----------------------------------------------------------------
    localparam int unsigned BC_RESET      = 15;
    localparam int unsigned BC_LOOPBACK   = 14;
    localparam int unsigned BC_SPEED      = 13;
    localparam int unsigned BC_AN_EN      = 12;
    localparam int unsigned BC_POWER_DOWN = 11;
    localparam int unsigned BC_ISOLATE    = 10;
    localparam int unsigned BC_AN_RESTART = 9;
    localparam int unsigned BC_DUPLEX     = 8;
    localparam logic [15:0] BC_RESET_VALUE = 16'h0100;
    localparam logic [15:0] BC_RW_MASK     = 16'hff80;

    // -----------------------------------------------------------------
    // External MAC port control fields
    // -----------------------------------------------------------------
    localparam int unsigned EXT_A_RX_PAUSE = 3;
    localparam int unsigned EXT_A_SPEED_LO = 4;
    localparam int unsigned EXT_A_TX_PAUSE = 5;
    localparam int unsigned EXT_A_DUPLEX   = 6;
    localparam int unsigned EXT_B_SPEED_HI = 6;
    localparam logic [7:0]  EXT_A_RESET    = 8'h00;
    localparam logic [7:0]  EXT_B_RESET    = 8'h00;

    // Pause advertisement sits in bits 11:10 of its register.
    localparam int unsigned ADV_PAUSE_LO   = 10;
    localparam logic [1:0]  ADV_RESET      = 2'h0;

    // -----------------------------------------------------------------
    // Status byte fields
    // -----------------------------------------------------------------
    localparam int unsigned ST_RX_PAUSE = 0;
    localparam int unsigned ST_TX_PAUSE = 1;
    localparam int unsigned ST_DUPLEX   = 2;
    localparam int unsigned ST_SPEED_LO = 3;
    localparam logic [1:0]  SPEED_10    = 2'h0;
    localparam logic [1:0]  SPEED_100   = 2'h1;
    localparam logic [1:0]  SPEED_1000  = 2'h2;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 25;
    localparam int unsigned PHY_RESET_NS     = 1000;
    localparam int unsigned PHY_RESET_CYCLES =
        (PHY_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WAKE_WAIT_US     = 1000;
    localparam int unsigned WAKE_WAIT_CYCLES = WAKE_WAIT_US * CLK_MHZ;
    localparam int unsigned TIMER_W          = 16;
    localparam int unsigned SYNC_W           = 9;
    localparam logic [1:0]  SETTLE_DONE      = 2'h2;

endpackage

// ### rtl/phy_timer_if.sv
// Interface between the control register logic and its delay timer.
`timescale 1ns/1ps
`default_nettype none
interface phy_timer_if;
    logic        start;
    logic [15:0] load;
    logic        busy;
    logic        done;
    modport ctl (output start, output load, input busy, input done);
    modport tmr (input start, input load, output busy, output done);
endinterface
`default_nettype wire

// ### rtl/phy_delay_timer.sv
// Down-counting delay timer used for PHY reset and wake-up waits.
`timescale 1ns/1ps
`default_nettype none
module phy_delay_timer (
    input  wire logic      core_clk, // Core clock.
    input  wire logic      rst,      // Synchronous reset, active high.
    phy_timer_if.tmr       tmr       // Start/load in, busy/done out.
);
    typedef struct packed {
        logic [port_regs_pkg::TIMER_W-1:0] cnt;
        logic                              busy;
    } tstate_t;

    tstate_t state_ff;
    tstate_t nxt_state;

    // A load of zero is treated as one so that done always pulses.
    always_comb begin
        nxt_state = state_ff;
        if (tmr.start) begin
            nxt_state.busy = 1'b1;
            nxt_state.cnt  = (tmr.load == 16'h0000) ? 16'h0001 : tmr.load;
        end else if (state_ff.busy) begin
            nxt_state.cnt = state_ff.cnt - 16'h0001;
            if (state_ff.cnt == 16'h0001) begin
                nxt_state.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tmr.busy = state_ff.busy;
    // Done ignores start, so the control logic may re-arm the timer in the
    // same cycle without forming a combinational loop through start.
    assign tmr.done = state_ff.busy && (state_ff.cnt == 16'h0001);
endmodule
`default_nettype wire

// ### rtl/port_status_phy_basic_control.sv
// Port status byte and PHY basic control word behind an Avalon-MM slave.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module port_status_phy_basic_control #(
    parameter int unsigned WAKE_CYCLES = port_regs_pkg::WAKE_WAIT_CYCLES
) (
    input  wire logic        core_clk,              // Core clock, 25 MHz.
    input  wire logic        rst,                   // Sync reset, high.
    input  wire logic [11:0] avs_address,           // Byte address.
    input  wire logic        avs_read,              // Read request.
    input  wire logic        avs_write,             // Write request.
    input  wire logic [31:0] avs_writedata,         // Write data.
    input  wire logic [3:0]  avs_byteenable,        // Byte lanes.
    output logic      [31:0] avs_readdata,          // Read data.
    output logic             avs_waitrequest,       // Stall request.
    input  wire logic        port_is_phy,           // Strap: PHY port.
    input  wire logic        an_strap,              // Strap: negotiation.
    input  wire logic        speed_strap,           // Strap: 100 Mb/s.
    input  wire logic        phy_link_up,           // Link is up.
    input  wire logic [1:0]  phy_speed,             // Resolved speed.
    input  wire logic        phy_full_duplex,       // Resolved duplex.
    input  wire logic        phy_tx_pause_resolved, // Tx pause agreed.
    input  wire logic        phy_rx_pause_resolved, // Rx pause agreed.
    output logic             phy_reset,             // PHY core reset.
    output logic             phy_power_down,        // Power-down mode.
    output logic             phy_isolate,           // Isolate PHY.
    output logic             phy_loopback,          // Local loopback.
    output logic             phy_an_enable,         // Negotiation on.
    output logic             phy_force_100,         // Forced 100 Mb/s.
    output logic             phy_force_full_duplex, // Forced duplex.
    output logic             phy_an_restart,        // Restart pulse.
    output logic             phy_busy               // Wake-up wait.
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [port_regs_pkg::SYNC_W-1:0] sync1;
        logic [port_regs_pkg::SYNC_W-1:0] sync2;
        logic [1:0]                       settle;
        logic                             strap_taken;
        logic                             ack;
        logic [31:0]                      rdata;
        logic [15:0]                      ctrl;
        logic [7:0]                       ext_a;
        logic [7:0]                       ext_b;
        logic [1:0]                       adv;
        logic [7:0]                       status;
        logic                             rst_active;
        logic                             wake_wait;
        logic                             an_restart;
        logic                             force_100;
        logic                             force_fdx;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    phy_timer_if tmr_if ();

    phy_delay_timer u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .tmr      (tmr_if.tmr)
    );

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic in_phy_win(input logic [11:0] a);
        return (a >= port_regs_pkg::PHY_WIN_LO) &&
               (a <= port_regs_pkg::PHY_WIN_HI);
    endfunction

    // Synchronised view of the pins; only sync2 is ever read by logic.
    logic       s_is_phy;
    logic       s_an_strap;
    logic       s_speed_strap;
    logic       s_link;
    logic [1:0] s_speed;
    logic       s_fdx;
    logic       s_txr;
    logic       s_rxr;
    assign {s_is_phy, s_an_strap, s_speed_strap, s_link, s_speed, s_fdx,
            s_txr, s_rxr} = state_ff.sync2;

    logic req;
    logic take;
    assign req  = avs_read || avs_write;
    assign take = req && state_ff.ack;

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        logic [15:0] wctrl;
        logic        ctrl_hit;
        logic        pause_adv;
        wctrl     = 16'h0000;
        ctrl_hit  = 1'b0;
        pause_adv = 1'b0;
        nxt_state = state_ff;
        tmr_if.start = 1'b0;
        tmr_if.load  = 16'h0000;

        nxt_state.sync1 = {port_is_phy, an_strap, speed_strap, phy_link_up,
                           phy_speed, phy_full_duplex,
                           phy_tx_pause_resolved, phy_rx_pause_resolved};
        nxt_state.sync2 = state_ff.sync1;

        // Straps are caught once the synchronisers have filled.
        if (state_ff.settle != port_regs_pkg::SETTLE_DONE) begin
            nxt_state.settle = state_ff.settle + 2'h1;
        end else if (!state_ff.strap_taken) begin
            nxt_state.strap_taken = 1'b1;
            nxt_state.ctrl[port_regs_pkg::BC_AN_EN] =
                s_an_strap && s_is_phy;
            nxt_state.ctrl[port_regs_pkg::BC_SPEED] =
                s_speed_strap && s_is_phy;
        end

        // The restart request is seen for exactly one cycle.
        nxt_state.an_restart = 1'b0;
        if (state_ff.ctrl[port_regs_pkg::BC_AN_RESTART]) begin
            nxt_state.ctrl[port_regs_pkg::BC_AN_RESTART] = 1'b0;
        end

        // Reset finished: self-clearing bit drops with the timer.
        if (tmr_if.done) begin
            nxt_state.rst_active = 1'b0;
            nxt_state.wake_wait  = 1'b0;
            nxt_state.ctrl[port_regs_pkg::BC_RESET] = 1'b0;
        end

        // Bus handshake: one wait cycle, held until straps are in.
        nxt_state.ack = req && !state_ff.ack && state_ff.strap_taken;

        if (avs_read && !state_ff.ack) begin
            nxt_state.rdata = 32'h0000_0000;
            if (in_phy_win(avs_address)) begin
                if (s_is_phy &&
                    avs_address == port_regs_pkg::OFF_PHY_BASIC_CONTROL) begin
                    nxt_state.rdata[15:0] = state_ff.ctrl;
                end
            end else begin
                case (avs_address)
                    port_regs_pkg::OFF_PORT_LINK_STATUS: begin
                        nxt_state.rdata[7:0] = state_ff.status;
                    end
                    port_regs_pkg::OFF_EXT_MAC_CTRL_A: begin
                        nxt_state.rdata[7:0] = state_ff.ext_a;
                    end
                    port_regs_pkg::OFF_EXT_MAC_CTRL_B: begin
                        nxt_state.rdata[7:0] = state_ff.ext_b;
                    end
                    port_regs_pkg::OFF_PAUSE_ADVERT: begin
                        nxt_state.rdata[11:10] = state_ff.adv;
                    end
                    port_regs_pkg::OFF_PHY_STATE: begin
                        nxt_state.rdata[1:0] = {state_ff.wake_wait,
                                                state_ff.rst_active};
                    end
                    default: begin
                        nxt_state.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Writes take effect at the edge where waitrequest is low.
        if (avs_write && take) begin
            ctrl_hit = s_is_phy &&
                avs_address == port_regs_pkg::OFF_PHY_BASIC_CONTROL;
            case (avs_address)
                port_regs_pkg::OFF_EXT_MAC_CTRL_A: begin
                    if (avs_byteenable[0]) begin
                        nxt_state.ext_a = avs_writedata[7:0];
                    end
                end
                port_regs_pkg::OFF_EXT_MAC_CTRL_B: begin
                    if (avs_byteenable[0]) begin
                        nxt_state.ext_b = avs_writedata[7:0];
                    end
                end
                port_regs_pkg::OFF_PAUSE_ADVERT: begin
                    if (avs_byteenable[1]) begin
                        nxt_state.adv = avs_writedata[11:10];
                    end
                end
                default: begin
                    nxt_state.adv = nxt_state.adv;
                end
            endcase
            if (ctrl_hit) begin
                wctrl = merge16(state_ff.ctrl, avs_writedata[15:0],
                                avs_byteenable[1:0]);
                // A pending reset cannot be cancelled by writing zero.
                wctrl[port_regs_pkg::BC_RESET] = wctrl[port_regs_pkg::BC_RESET]
                    || nxt_state.ctrl[port_regs_pkg::BC_RESET];
                nxt_state.ctrl = (wctrl & port_regs_pkg::BC_RW_MASK) |
                    (state_ff.ctrl & ~port_regs_pkg::BC_RW_MASK);
                if (avs_byteenable[1] &&
                    wctrl[port_regs_pkg::BC_AN_RESTART]) begin
                    nxt_state.an_restart = 1'b1;
                end
                if (state_ff.ctrl[port_regs_pkg::BC_POWER_DOWN] &&
                    !wctrl[port_regs_pkg::BC_POWER_DOWN]) begin
                    // Wake-up: internal reset plus the long wait.
                    nxt_state.rst_active = 1'b1;
                    nxt_state.wake_wait  = 1'b1;
                    nxt_state.ctrl[port_regs_pkg::BC_RESET] = 1'b1;
                    tmr_if.start = 1'b1;
                    tmr_if.load  = WAKE_CYCLES[15:0];
                end else if (avs_byteenable[1] &&
                             avs_writedata[port_regs_pkg::BC_RESET] &&
                             !nxt_state.rst_active) begin
                    nxt_state.rst_active = 1'b1;
                    tmr_if.start = 1'b1;
                    tmr_if.load  = port_regs_pkg::PHY_RESET_CYCLES[15:0];
                end
            end
        end

        // Forced speed/duplex only matter with negotiation off.
        nxt_state.force_100 = !nxt_state.ctrl[port_regs_pkg::BC_AN_EN] &&
            nxt_state.ctrl[port_regs_pkg::BC_SPEED];
        nxt_state.force_fdx = !nxt_state.ctrl[port_regs_pkg::BC_AN_EN] &&
            nxt_state.ctrl[port_regs_pkg::BC_DUPLEX];

        // Status byte is rebuilt every cycle and never written.
        nxt_state.status = 8'h00;
        pause_adv = |state_ff.adv;
        if (s_is_phy) begin
            nxt_state.status[4:3] = s_speed;
            nxt_state.status[port_regs_pkg::ST_DUPLEX] = s_fdx;
            nxt_state.status[port_regs_pkg::ST_TX_PAUSE] =
                pause_adv && s_link && s_txr;
            nxt_state.status[port_regs_pkg::ST_RX_PAUSE] =
                pause_adv && s_link && s_rxr;
        end else begin
            nxt_state.status[4:3] = {
                state_ff.ext_b[port_regs_pkg::EXT_B_SPEED_HI],
                state_ff.ext_a[port_regs_pkg::EXT_A_SPEED_LO]};
            nxt_state.status[port_regs_pkg::ST_DUPLEX] =
                state_ff.ext_a[port_regs_pkg::EXT_A_DUPLEX];
            nxt_state.status[port_regs_pkg::ST_TX_PAUSE] =
                state_ff.ext_a[port_regs_pkg::EXT_A_TX_PAUSE];
            nxt_state.status[port_regs_pkg::ST_RX_PAUSE] =
                state_ff.ext_a[port_regs_pkg::EXT_A_RX_PAUSE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff       <= '0;
            state_ff.ctrl  <= port_regs_pkg::BC_RESET_VALUE;
            state_ff.ext_a <= port_regs_pkg::EXT_A_RESET;
            state_ff.ext_b <= port_regs_pkg::EXT_B_RESET;
            state_ff.adv   <= port_regs_pkg::ADV_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign avs_readdata    = state_ff.rdata;
    assign avs_waitrequest = !state_ff.ack;
    assign phy_reset       = state_ff.rst_active;
    assign phy_busy        = state_ff.wake_wait;
    assign phy_power_down  = state_ff.ctrl[port_regs_pkg::BC_POWER_DOWN];
    assign phy_isolate     = state_ff.ctrl[port_regs_pkg::BC_ISOLATE];
    assign phy_loopback    = state_ff.ctrl[port_regs_pkg::BC_LOOPBACK];
    assign phy_an_enable   = state_ff.ctrl[port_regs_pkg::BC_AN_EN];
    assign phy_force_100   = state_ff.force_100;
    assign phy_force_full_duplex = state_ff.force_fdx;
    assign phy_an_restart  = state_ff.an_restart;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_ctrl_write;
        avs_write && !avs_waitrequest && s_is_phy &&
        avs_address == port_regs_pkg::OFF_PHY_BASIC_CONTROL &&
        avs_byteenable[1];
    endsequence

    sequence s_sreset_req;
        s_ctrl_write ##0 avs_writedata[15] && !state_ff.rst_active &&
        !(state_ff.ctrl[11] && !avs_writedata[11]);
    endsequence

    a_ext_status_copy: assert property (
        !s_is_phy |=> state_ff.status[4:0] == {$past(state_ff.ext_b[6]),
            $past(state_ff.ext_a[4]), $past(state_ff.ext_a[6]),
            $past(state_ff.ext_a[5]), $past(state_ff.ext_a[3])})
        else $error("external port status does not copy control bits");

    a_phy_speed_dup: assert property (
        s_is_phy && $stable(s_is_phy) |=> state_ff.status[4:2] ==
            {$past(s_speed), $past(s_fdx)})
        else $error("PHY status speed or duplex wrong");

    a_phy_pause_gate: assert property (
        $past(s_is_phy) && state_ff.status[1] |-> $past(s_link) &&
            ($past(state_ff.adv) != 2'h0))
        else $error("pause status set without advert or link");

    a_window_phy_only: assert property (
        avs_read && !avs_waitrequest && !$past(s_is_phy) &&
        avs_address == port_regs_pkg::OFF_PHY_BASIC_CONTROL
        |-> avs_readdata == 32'h0000_0000)
        else $error("PHY window answered on a non-PHY port");

    a_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest && state_ff.strap_taken
        |=> !avs_waitrequest)
        else $error("slave did not answer after one wait cycle");

    a_sreset_self_clear: assert property (
        s_sreset_req |=> phy_reset ##[20:30] !state_ff.ctrl[15] && !phy_reset)
        else $error("software reset did not clear in time");

    a_forced_speed: assert property (
        state_ff.ctrl[12] |-> !phy_force_100)
        else $error("forced speed active with negotiation on");

    a_strap_load: assert property (
        $rose(state_ff.strap_taken) |-> phy_an_enable ==
            ($past(s_an_strap) && $past(s_is_phy)))
        else $error("negotiation default not taken from strap");

    a_wake_reset: assert property (
        s_ctrl_write ##0 state_ff.ctrl[11] && !avs_writedata[11]
        |=> (phy_busy && phy_reset) [*8])
        else $error("leaving power down did not start reset and wait");

    a_restart_pulse: assert property (
        phy_an_restart |=> !phy_an_restart && !state_ff.ctrl[9])
        else $error("restart request did not clear after one cycle");

    a_status_upper_zero: assert property (
        state_ff.status[7:5] == 3'h0)
        else $error("reserved status bits not zero");
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the port status byte and PHY basic control word.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic        core_clk = 0, rst = 1, rd = 0, wr = 0, is_phy = 0, wq;
    logic        lk = 0, fd = 0, tp = 0, rp = 0, busy, rstp, lb, an, f100, anr;
    logic        pd, iso, ffd, sa = 1, ss = 0;
    logic [1:0]  sp = 2'h0;
    logic [11:0] ad = 12'h000;
    logic [31:0] wd = 32'h0000_0000, q, rdata;
    int          err_count = 0, num_checks = 0, n;
    initial forever #20 core_clk = ~core_clk;
    port_status_phy_basic_control #(.WAKE_CYCLES(40)) uut (
        .core_clk(core_clk), .rst(rst), .avs_address(ad), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wq), .port_is_phy(is_phy),
        .an_strap(sa), .speed_strap(ss), .phy_link_up(lk),
        .phy_speed(sp), .phy_full_duplex(fd), .phy_tx_pause_resolved(tp),
        .phy_rx_pause_resolved(rp), .phy_reset(rstp), .phy_power_down(pd),
        .phy_isolate(iso), .phy_loopback(lb), .phy_an_enable(an),
        .phy_force_100(f100), .phy_force_full_duplex(ffd),
        .phy_an_restart(anr), .phy_busy(busy));
    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // The request is held until waitrequest is sampled low at a rising edge;
    // read data is taken and the request released at that same edge.
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        begin
            @(posedge core_clk);
            ad <= a; wr <= w; rd <= !w; wd <= d;
            k = 0;
            @(posedge core_clk);
            while (wq !== 1'b0) begin
                k++;
                if (k > 50) begin err_count++; stop_test(); end
                @(posedge core_clk);
            end
            q = rdata;
            wr <= 1'b0; rd <= 1'b0;
        end
    endtask
    task cnt(input int s, input int len);
        begin
            n = 0;
            repeat (len) begin
                @(posedge core_clk);
                if ((s == 0 ? anr : s == 1 ? rstp : busy) === 1'b1) n++;
            end
        end
    endtask
    task do_reset;
        begin
            rst <= 1'b1;
            repeat (12) @(posedge core_clk);
            rst <= 1'b0;
        end
    endtask
    task t_ext;
        begin
            bus(1, 12'h040, 32'h0000_0068); bus(1, 12'h044, 32'h0000_0040);
            bus(1, 12'h030, 32'h0000_00ff); bus(0, 12'h030, 32'h0000_0000);
            `CHK("ext status", 32'h0000_0017, q)
            bus(1, 12'h100, 32'h0000_ffff); bus(0, 12'h100, 32'h0000_0000);
            `CHK("no phy window", 32'h0000_0000, q)
        end
    endtask
    task t_phy;
        begin
            bus(0, 12'h100, 32'h0000_0000);
            `CHK("ctrl default", 32'h0000_1100, q)
            lk <= 1'b1; sp <= 2'h2; fd <= 1'b1; tp <= 1'b1; rp <= 1'b1;
            repeat (4) @(posedge core_clk);
            bus(0, 12'h030, 32'h0000_0000);
            `CHK("phy no advert", 32'h0000_0014, q)
            bus(1, 12'h048, 32'h0000_0400); bus(0, 12'h030, 32'h0000_0000);
            `CHK("phy advert", 32'h0000_0017, q)
            lk <= 1'b0; sp <= 2'h1; fd <= 1'b0;
            repeat (4) @(posedge core_clk);
            bus(0, 12'h030, 32'h0000_0000);
            `CHK("link down", 32'h0000_0008, q)
        end
    endtask
    task t_ctrl;
        begin
            bus(1, 12'h100, 32'h0000_6500); @(posedge core_clk);
            `CHK("loopback", 1'b1, lb)
            `CHK("force 100", 1'b1, f100)
            `CHK("an off", 1'b0, an)
            `CHK("isolate", 1'b1, iso)
            `CHK("force full", 1'b1, ffd)
            bus(1, 12'h100, 32'h0000_3100); @(posedge core_clk);
            `CHK("speed ignored", 1'b0, f100)
            `CHK("duplex ignored", 1'b0, ffd)
            bus(1, 12'h100, 32'h0000_1200); cnt(0, 3);
            `CHK("restart pulse", 1, n)
            bus(0, 12'h100, 32'h0000_0000);
            `CHK("restart clear", 32'h0000_1000, q)
            bus(1, 12'h100, 32'h0000_9000); cnt(1, 40);
            `CHK("reset length", 25, n)
            bus(0, 12'h100, 32'h0000_0000);
            `CHK("reset kept regs", 32'h0000_1000, q)
            bus(1, 12'h100, 32'h0000_1800); @(posedge core_clk);
            `CHK("power down", 1'b1, pd)
            bus(1, 12'h100, 32'h0000_1000); cnt(2, 60);
            `CHK("wake wait", 40, n)
            bus(0, 12'h100, 32'h0000_0000);
            `CHK("wake done", 32'h0000_1000, q)
        end
    endtask
    initial begin
        do_reset();
        t_ext();
        is_phy <= 1'b1;
        do_reset();
        t_phy();
        t_ctrl();
        stop_test();
    end
endmodule
`default_nettype wire
